//--- bridge_port_identity_command.sv
// Identity and command registers of a switch downstream bridge port
//
// Summary of operation
// - Maker identity reads fixed value, ignores writes
// - Part identity reads fixed value, follows maker
// - I/O enable off: no I/O window claims
// - Memory enable off: no memory window claims
// - Forward enable off: refuse upstream memory, I/O
// - Forward enable off: UR completion for non-posted memory, I/O
// - Completions and messages always pass upstream
// - Enables: zero off, one on, reset zero
// - Bits 3, 4, 5, 7 read zero
// - Parity bit stored, reset zero, no effect
`timescale 1ns/1ps
`default_nettype none
module bridge_port_identity_command
#(
    parameter logic [15:0] MAKER_IDENTITY = bridge_cfg_pkg::MAKER_IDENTITY_DEFAULT, // Arbitrary value
    parameter logic [15:0] PART_IDENTITY = bridge_cfg_pkg::PART_IDENTITY_DEFAULT // Arbitrary value
)
(
    input wire logic core_clk, // Port core clock, 100 MHz
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic cfg_valid, // Configuration access request
    output logic cfg_ready, // Access can be taken
    input wire bridge_cfg_pkg::cfg_access_t cfg_access, // Access fields
    output logic cfg_ack, // Access answered
    output logic [31:0] cfg_rdata, // Read data
    input wire logic pri_valid, // Primary-side request present
    input wire bridge_cfg_pkg::req_kind_t pri_kind, // Primary request class
    input wire logic pri_window_hit, // Address inside a base/limit window
    output logic pri_claim, // Port claims the request
    input wire logic up_valid, // Subordinate request present
    input wire bridge_cfg_pkg::up_req_t up_req, // Subordinate request class
    output logic up_forward, // Pass request upstream
    output logic up_unsupported, // Request refused
    output logic up_ur_completion, // Send unsupported-request completion
    output bridge_cfg_pkg::command_t command // Current enables
);
    import bridge_cfg_pkg::*;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    localparam logic [DWORD_ADDR_W-1:0] DW_IDENTITY = OFS_MAKER_IDENTITY[11:2]; // Identity dword
    localparam logic [DWORD_ADDR_W-1:0] DW_COMMAND = OFS_BRIDGE_COMMAND[11:2]; // Command dword

    logic take; // Access taken this edge
    logic hit_identity; // Access names the identity dword
    logic hit_command; // Access names the command dword
    logic cmd_lane0_write; // Write that reaches the command low byte

    // Decode of the current access
    always_comb
    begin
        take = cfg_valid && cfg_ready;
        hit_identity = cfg_access.dword_addr == DW_IDENTITY;
        hit_command = cfg_access.dword_addr == DW_COMMAND;
        cmd_lane0_write = take && cfg_access.write && hit_command && cfg_access.byte_en[0];
    end

    // ------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------
    cfg_state_t state_reg, state_next; // One-hot access state

    // Idle takes an access, answer acknowledges it for one cycle
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE:
            begin
                if (cfg_valid)
                begin
                    state_next = ST_ANSWER;
                end
            end
            ST_ANSWER:
            begin
                state_next = ST_IDLE;
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= ST_IDLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Handshake outputs straight from the state
    assign cfg_ready = state_reg == ST_IDLE;
    assign cfg_ack = state_reg == ST_ANSWER;

    // ------------------------------------------------------------
    // Command register
    // ------------------------------------------------------------
    command_t command_reg, command_next; // Writable command bits

    // Only the low byte holds storage; identity and fixed bits are untouched
    always_comb
    begin
        command_next = command_reg;
        if (cmd_lane0_write)
        begin
            command_next.io_window_enable = cfg_access.wdata[CMD_IO_POS];
            command_next.memory_window_enable = cfg_access.wdata[CMD_MEM_POS];
            command_next.request_forward_enable = cfg_access.wdata[CMD_FWD_POS];
            command_next.parity_response_bit = cfg_access.wdata[CMD_PARITY_POS];
        end
    end

    // Command storage, all off after reset
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            command_reg.io_window_enable <= RESET_BIT_VALUE;
            command_reg.memory_window_enable <= RESET_BIT_VALUE;
            command_reg.request_forward_enable <= RESET_BIT_VALUE;
            command_reg.parity_response_bit <= RESET_BIT_VALUE;
        end
        else
        begin
            command_reg <= command_next;
        end
    end

    assign command = command_reg;

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [15:0] command_view; // Command word as software sees it
    logic [31:0] cfg_rdata_reg, cfg_rdata_next; // Registered read data

    // Assemble the command word with fixed zero bits
    always_comb
    begin
        command_view = 16'h0000;
        command_view[CMD_IO_POS] = command_reg.io_window_enable;
        command_view[CMD_MEM_POS] = command_reg.memory_window_enable;
        command_view[CMD_FWD_POS] = command_reg.request_forward_enable;
        command_view[CMD_SPECIAL_POS] = 1'h0;
        command_view[CMD_WINV_POS] = 1'h0;
        command_view[CMD_PALETTE_POS] = 1'h0;
        command_view[CMD_PARITY_POS] = command_reg.parity_response_bit;
        command_view[CMD_STEP_POS] = 1'h0;
    end

    // Read value captured when an access is taken, held otherwise
    always_comb
    begin
        cfg_rdata_next = cfg_rdata_reg;
        if (take)
        begin
            if (cfg_access.write)
            begin
                // Writes answer with zero data
                cfg_rdata_next = 32'h0000_0000;
            end
            else if (hit_identity)
            begin
                // Fixed identity codes, writes never reach them
                cfg_rdata_next = {PART_IDENTITY, MAKER_IDENTITY};
            end
            else if (hit_command)
            begin
                // Status half lives elsewhere and reads zero here
                cfg_rdata_next = {16'h0000, command_view};
            end
            else
            begin
                // Unmapped dwords read zero
                cfg_rdata_next = 32'h0000_0000;
            end
        end
    end

    // Read data register
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_rdata_reg <= 32'h0000_0000;
        end
        else
        begin
            cfg_rdata_reg <= cfg_rdata_next;
        end
    end

    assign cfg_rdata = cfg_rdata_reg;

    // ------------------------------------------------------------
    // Primary-side window claim
    // ------------------------------------------------------------
    logic pri_claim_reg, pri_claim_next; // Registered claim

    // Claim only window hits whose space is enabled
    always_comb
    begin
        pri_claim_next = 1'h0;
        if (pri_valid && pri_window_hit)
        begin
            unique case (pri_kind)
                KIND_IO:
                begin
                    pri_claim_next = command_reg.io_window_enable;
                end
                KIND_MEM:
                begin
                    pri_claim_next = command_reg.memory_window_enable;
                end
                KIND_MSG, KIND_CPL:
                begin
                    // Windows decode only memory and I/O
                    pri_claim_next = 1'h0;
                end
            endcase
        end
    end

    // Claim register
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pri_claim_reg <= 1'h0;
        end
        else
        begin
            pri_claim_reg <= pri_claim_next;
        end
    end

    assign pri_claim = pri_claim_reg;

    // ------------------------------------------------------------
    // Upstream gate
    // ------------------------------------------------------------
    // Subordinate traffic is judged against the forward enable
    upstream_gate u_upstream_gate
    (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .fwd_en(command_reg.request_forward_enable),
        .up_valid(up_valid),
        .up_req(up_req),
        .up_forward(up_forward),
        .up_unsupported(up_unsupported),
        .up_ur_completion(up_ur_completion)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    identity_read_a: assert property (
        take && !cfg_access.write && hit_identity
        |=> cfg_ack && cfg_rdata == {PART_IDENTITY, MAKER_IDENTITY})
        else $error("identity read returned wrong value");

    part_after_write_a: assert property (
        take && cfg_access.write && hit_identity
        ##[2:8] take && !cfg_access.write && hit_identity
        |=> cfg_rdata[31:16] == PART_IDENTITY)
        else $error("part identity changed by a write");

    io_claim_gate_a: assert property (
        pri_valid && pri_window_hit && pri_kind == KIND_IO
        |=> pri_claim == $past(command_reg.io_window_enable))
        else $error("I/O claim disagrees with enable");

    mem_claim_gate_a: assert property (
        pri_valid && pri_window_hit && pri_kind == KIND_MEM
        |=> pri_claim == $past(command_reg.memory_window_enable))
        else $error("memory claim disagrees with enable");

    reset_enables_a: assert property (
        $rose(rst_n) |-> command_reg == 4'h0 && !pri_claim && !up_forward)
        else $error("enables not cleared by reset");

    fixed_zero_a: assert property (
        cfg_ack && $past(hit_command) && !$past(cfg_access.write)
        |-> cfg_rdata[CMD_SPECIAL_POS] == 1'h0 && cfg_rdata[CMD_WINV_POS] == 1'h0
            && cfg_rdata[CMD_PALETTE_POS] == 1'h0 && cfg_rdata[CMD_STEP_POS] == 1'h0)
        else $error("fixed command bit read as one");

    parity_store_a: assert property (
        cmd_lane0_write
        |=> command_reg.parity_response_bit == $past(cfg_access.wdata[CMD_PARITY_POS])
            && command_reg.request_forward_enable == $past(cfg_access.wdata[CMD_FWD_POS]))
        else $error("command write not stored");

    lane_gate_a: assert property (
        !cmd_lane0_write |=> $stable(command_reg))
        else $error("command changed without a lane 0 write");

    ack_timing_a: assert property (
        take |=> cfg_ack ##1 !cfg_ack && cfg_ready)
        else $error("access answer not one cycle after take");

endmodule // bridge_port_identity_command
`default_nettype wire

//--- bridge_cfg_pkg.sv
// Shared constants, field layouts and types of the bridge identity and command block
`default_nettype none
package bridge_cfg_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte offsets in configuration space)
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_MAKER_IDENTITY = 12'h000; // Lanes 1:0 of dword 0
    localparam logic [11:0] OFS_PART_IDENTITY = 12'h002; // Lanes 3:2 of dword 0
    localparam logic [11:0] OFS_BRIDGE_COMMAND = 12'h004; // Lanes 1:0 of dword 1
    localparam int DWORD_ADDR_W = 10; // Dword index width of a 4 KB space

    // ------------------------------------------------------------
    // Command field positions
    // ------------------------------------------------------------
    localparam int CMD_IO_POS = 0; // I/O window decode enable
    localparam int CMD_MEM_POS = 1; // Memory window decode enable
    localparam int CMD_FWD_POS = 2; // Upstream request forwarding enable
    localparam int CMD_SPECIAL_POS = 3; // Special cycle, fixed zero
    localparam int CMD_WINV_POS = 4; // Write invalidate, fixed zero
    localparam int CMD_PALETTE_POS = 5; // Palette snoop, fixed zero
    localparam int CMD_PARITY_POS = 6; // Parity response, storage only
    localparam int CMD_STEP_POS = 7; // Address stepping, fixed zero

    // ------------------------------------------------------------
    // Reset and identity values
    // ------------------------------------------------------------
    localparam logic RESET_BIT_VALUE = 1'h0; // Every enable comes up off
    localparam logic [15:0] MAKER_IDENTITY_DEFAULT = 16'h5a5a; // Arbitrary value
    localparam logic [15:0] PART_IDENTITY_DEFAULT = 16'ha5a5; // Arbitrary value

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic parity_response_bit; // Stored, no effect
        logic request_forward_enable; // Gates upstream memory and I/O
        logic memory_window_enable; // Gates memory window claims
        logic io_window_enable; // Gates I/O window claims
    } command_t;

    typedef struct packed {
        logic write; // One for write, zero for read
        logic [DWORD_ADDR_W-1:0] dword_addr; // Dword index
        logic [3:0] byte_en; // Byte lane enables
        logic [31:0] wdata; // Write data
    } cfg_access_t;

    typedef enum logic [1:0] {
        KIND_MEM = 2'h0,
        KIND_IO = 2'h1,
        KIND_MSG = 2'h2,
        KIND_CPL = 2'h3
    } req_kind_t;

    typedef struct packed {
        req_kind_t kind; // Transaction class
        logic non_posted; // Needs a completion
    } up_req_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_ANSWER = 2'b10
    } cfg_state_t;

endpackage
`default_nettype wire

//--- upstream_gate.sv
// Upstream request gate: forwards or refuses subordinate traffic
`timescale 1ns/1ps
`default_nettype none
module upstream_gate
(
    input wire logic core_clk, // Port core clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic fwd_en, // Request forwarding enable
    input wire logic up_valid, // Subordinate request present
    input wire bridge_cfg_pkg::up_req_t up_req, // Request class
    output logic up_forward, // Pass request upstream
    output logic up_unsupported, // Request refused
    output logic up_ur_completion // Send unsupported-request completion
);
    import bridge_cfg_pkg::*;

    // ------------------------------------------------------------
    // Decision logic
    // ------------------------------------------------------------
    logic blocked; // Memory or I/O with forwarding off
    logic up_forward_reg, up_forward_next; // Forward strobe
    logic up_unsupported_reg, up_unsupported_next; // Refusal strobe
    logic up_ur_completion_reg, up_ur_completion_next; // UR completion strobe

    // Next values of the three strobes
    always_comb
    begin
        blocked = up_valid && !fwd_en && (up_req.kind == KIND_MEM || up_req.kind == KIND_IO);
        up_forward_next = up_valid && !blocked;
        up_unsupported_next = blocked;
        up_ur_completion_next = blocked && up_req.non_posted;
    end

    // Strobe registers
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            up_forward_reg <= 1'h0;
            up_unsupported_reg <= 1'h0;
            up_ur_completion_reg <= 1'h0;
        end
        else
        begin
            up_forward_reg <= up_forward_next;
            up_unsupported_reg <= up_unsupported_next;
            up_ur_completion_reg <= up_ur_completion_next;
        end
    end

    assign up_forward = up_forward_reg;
    assign up_unsupported = up_unsupported_reg;
    assign up_ur_completion = up_ur_completion_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    no_fwd_blocked_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        up_valid && !fwd_en && (up_req.kind == KIND_MEM || up_req.kind == KIND_IO)
        |=> !up_forward && up_unsupported)
        else $error("memory or I/O request forwarded while disabled");

    ur_cpl_np_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        up_valid && !fwd_en && up_req.non_posted && up_req.kind == KIND_MEM
        |=> up_ur_completion)
        else $error("non-posted request missed its UR completion");

    cpl_msg_pass_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        up_valid && (up_req.kind == KIND_CPL || up_req.kind == KIND_MSG)
        |=> up_forward && !up_unsupported && !up_ur_completion)
        else $error("completion or message blocked");

endmodule // upstream_gate
`default_nettype wire

//--- cfg_requester.sv
// Configuration requester model standing on the upstream side of the port
`timescale 1ns/1ps
`default_nettype none
module cfg_requester
(
    input wire logic core_clk, // Port core clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic req_go, // Start one access, one cycle
    input wire bridge_cfg_pkg::cfg_access_t req, // Access to issue
    output logic req_done, // Answer seen, one cycle
    output logic [31:0] req_rdata, // Data carried by the answer
    output logic cfg_valid, // Request towards the port
    output bridge_cfg_pkg::cfg_access_t cfg_access, // Fields towards the port
    input wire logic cfg_ready, // Port can take
    input wire logic cfg_ack, // Port answered
    input wire logic [31:0] cfg_rdata // Port read data
);
    import bridge_cfg_pkg::*;

    // ------------------------------------------------------------
    // Request, hold until taken, then collect the answer
    // ------------------------------------------------------------
    logic wait_reg; // Taken, answer still due

    // Released fields show the inverse of the last value, never stale data
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_valid <= 1'h0;
            cfg_access <= '1;
            wait_reg <= 1'h0;
            req_done <= 1'h0;
            req_rdata <= 32'h0;
        end
        else
        begin
            req_done <= wait_reg && cfg_ack;
            if (req_go)
            begin
                cfg_valid <= 1'h1;
                cfg_access <= req;
            end
            else if (cfg_valid && cfg_ready)
            begin
                cfg_valid <= 1'h0;
                cfg_access <= ~cfg_access;
                wait_reg <= 1'h1;
            end
            if (wait_reg && cfg_ack)
            begin
                req_rdata <= cfg_rdata;
                wait_reg <= 1'h0;
            end
        end
    end
endmodule // cfg_requester
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the bridge identity and command block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import bridge_cfg_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam logic [15:0] MAKER_ID = 16'h1234; // Arbitrary value
    localparam logic [15:0] PART_ID = 16'hbeef; // Arbitrary value
    logic core_clk = 1'h0;
    logic rst_n = 1'h0;
    logic req_go = 1'h0;
    cfg_access_t req = '0;
    logic req_done, cfg_valid, cfg_ready, cfg_ack, pri_claim;
    logic up_forward, up_unsupported, up_ur_completion;
    logic [31:0] req_rdata, cfg_rdata, rd;
    cfg_access_t cfg_access;
    logic pri_valid = 1'h0;
    req_kind_t pri_kind = KIND_MEM;
    logic pri_window_hit = 1'h0;
    logic up_valid = 1'h0;
    up_req_t up_req = '0;
    command_t command;
    int fail_count = 0;
    int n_checks = 0;
    int cycles = 0;

    // ------------------------------------------------------------
    // Clock, timeout, instances
    // ------------------------------------------------------------
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fail_count++;
            close_out();
        end
    end

    bridge_port_identity_command #(.MAKER_IDENTITY(MAKER_ID), .PART_IDENTITY(PART_ID)) uut (
        .core_clk(core_clk), .rst_n(rst_n), .cfg_valid(cfg_valid), .cfg_ready(cfg_ready),
        .cfg_access(cfg_access), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .pri_valid(pri_valid),
        .pri_kind(pri_kind), .pri_window_hit(pri_window_hit), .pri_claim(pri_claim),
        .up_valid(up_valid), .up_req(up_req), .up_forward(up_forward),
        .up_unsupported(up_unsupported), .up_ur_completion(up_ur_completion), .command(command));

    cfg_requester host (
        .core_clk(core_clk), .rst_n(rst_n), .req_go(req_go), .req(req), .req_done(req_done),
        .req_rdata(req_rdata), .cfg_valid(cfg_valid), .cfg_access(cfg_access),
        .cfg_ready(cfg_ready), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic close_out();
        if (fail_count == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t word got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t flag got %b expected %b", $time, got, exp);
        end
    endtask

    // One configuration access through the requester model
    task automatic cfg_op(input logic w, input logic [9:0] a, input logic [3:0] be, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        #1;
        req_go = 1'h1;
        req = '{write: w, dword_addr: a, byte_en: be, wdata: d};
        @(posedge core_clk);
        #1;
        req_go = 1'h0;
        while (req_done !== 1'b1 && n < 20)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        if (n == 20)
            chk_bit(1'b0, 1'b1);
        rd = req_rdata;
    endtask

    // ------------------------------------------------------------
    // Table of ordinary cases: enables, traffic, expected strobes
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] cmd; // Enables fwd, mem, io
        req_kind_t pk; // Primary class
        logic hit; // Window hit
        req_kind_t uk; // Subordinate class
        logic np; // Non-posted
        logic [3:0] exp; // claim, forward, unsupported, ur completion
    } gate_row_t;
    gate_row_t rows [9] = '{
        '{3'h0, KIND_MEM, 1'b1, KIND_MEM, 1'b1, 4'b0011}, '{3'h0, KIND_IO, 1'b1, KIND_IO, 1'b0, 4'b0010},
        '{3'h1, KIND_IO, 1'b1, KIND_MSG, 1'b1, 4'b1100}, '{3'h1, KIND_MEM, 1'b1, KIND_CPL, 1'b0, 4'b0100},
        '{3'h2, KIND_MEM, 1'b1, KIND_MEM, 1'b1, 4'b1011}, '{3'h2, KIND_MEM, 1'b0, KIND_IO, 1'b1, 4'b0011},
        '{3'h4, KIND_IO, 1'b1, KIND_MEM, 1'b1, 4'b0100}, '{3'h7, KIND_MSG, 1'b1, KIND_IO, 1'b0, 4'b0100},
        '{3'h7, KIND_CPL, 1'b1, KIND_MSG, 1'b0, 4'b0100}};

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (2) @(posedge core_clk);
        #1;
        rst_n = 1'h1;
        chk_word({28'h0, command}, 32'h0);
        cfg_op(1'b0, 10'h0, 4'hf, 32'h0);
        chk_word(rd, {PART_ID, MAKER_ID});
        cfg_op(1'b0, 10'h1, 4'hf, 32'h0);
        chk_word(rd, 32'h0);
        foreach (rows[i])
        begin
            cfg_op(1'b1, 10'h1, 4'h1, {29'h0, rows[i].cmd});
            cfg_op(1'b0, 10'h1, 4'hf, 32'h0);
            chk_word(rd, {29'h0, rows[i].cmd});
            pri_valid = 1'h1;
            pri_kind = rows[i].pk;
            pri_window_hit = rows[i].hit;
            up_valid = 1'h1;
            up_req = '{kind: rows[i].uk, non_posted: rows[i].np};
            @(posedge core_clk);
            #1;
            pri_valid = 1'h0;
            up_valid = 1'h0;
            chk_word({28'h0, pri_claim, up_forward, up_unsupported, up_ur_completion},
                {28'h0, rows[i].exp});
        end
        // Identity dword ignores writes
        cfg_op(1'b1, 10'h0, 4'hf, 32'hffffffff);
        cfg_op(1'b0, 10'h0, 4'hf, 32'h0);
        chk_word(rd, {PART_ID, MAKER_ID});
        // Lane 0 disabled leaves the command alone
        cfg_op(1'b1, 10'h1, 4'he, 32'hffffff40);
        cfg_op(1'b0, 10'h1, 4'hf, 32'h0);
        chk_word(rd, 32'h7);
        // All ones: fixed bits stay zero, parity bit stored
        cfg_op(1'b1, 10'h1, 4'hf, 32'hffffffff);
        cfg_op(1'b0, 10'h1, 4'hf, 32'h0);
        chk_word(rd, 32'h47);
        chk_word({28'h0, command}, 32'hf);
        // Parity bit alone changes no gating
        cfg_op(1'b1, 10'h1, 4'h1, 32'h40);
        up_valid = 1'h1;
        up_req = '{kind: KIND_MEM, non_posted: 1'b1};
        @(posedge core_clk);
        #1;
        up_valid = 1'h0;
        chk_word({29'h0, up_forward, up_unsupported, up_ur_completion}, 32'h3);
        // Unmapped dword reads zero
        cfg_op(1'b0, 10'h5, 4'hf, 32'h0);
        chk_word(rd, 32'h0);
        // Second reset in mid-run clears the enables
        cfg_op(1'b1, 10'h1, 4'h1, 32'h7);
        rst_n = 1'h0;
        repeat (2) @(posedge core_clk);
        #1;
        chk_word({28'h0, command}, 32'h0);
        rst_n = 1'h1;
        cfg_op(1'b0, 10'h1, 4'hf, 32'h0);
        chk_word(rd, 32'h0);
        close_out();
    end
endmodule // tb_top
`default_nettype wire
